// file: core/bisem_intc.sv
// interrupt status, enable, mapping, pin and mailbox logic of the bridge
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// [R1] active source sets its status bit
// [R2] status bits other than the host message bit clear only by writing one
// [R3] all status bits zero after reset
// [R4] all enable bits zero after reset
// [R5] pin asserted only for set, enabled status; doorbell status bits drive their pin with no enable bit
// [R6] normal register shows error summary bit
// [R7] error register shows normal summary bit
// [R8] host message bit mirrors outbound queue
// [R9] iop message bit set by inbound queue
// [R10] one status bit per dma channel
// [R11] eight pin input status and enable bits
// [R12] doorbell write one sets its status
// [R13] mailbox write sets mailbox status bit
// [R14] eight 32-bit read/write mailboxes
// [R15] host mask gates outbound queue interrupt
// [R16] three-bit map field per source
// [R17] direction bit makes pin input or output
// [R18] master errors flagged per source interface
// [R19] target errors flagged per destination port
// [R20] retry limit flagged per master and path
// [R21] cpu bus error on slave or master transfer error
// [R22] separate address parity bit per bus
// [R23] software reads pci status for details
// [R24] input pin sampled four edges before status
// [R25] pins open-drain, active low, inputs after reset
// [R26] doorbell cleared by writing one to status
// [R27] codes 0,1 pci pins, 2-7 general pins
// [R28] output pin low while mapped source active
module bisem_intc (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic [bisem_pkg::ADDR_W-1:0]  addr,
	input  wire logic [bisem_pkg::DATA_W-1:0]  wrData,
	input  wire logic                          wrStb,
	input  wire logic                          rdStb,
	output logic      [bisem_pkg::DATA_W-1:0]  rdData,
	input  wire logic                          outboundPending,
	input  wire logic                          inboundPending,
	input  wire logic [bisem_pkg::NUM_DMA-1:0] dmaIrq,
	input  wire logic [2:0]                    cpuBusRetryLimit,
	input  wire logic [2:0]                    cpuBusSlaveXferErr,
	input  wire logic [2:0]                    cpuBusMasterXferErr,
	input  wire logic                          cpuBusAddrParity,
	input  wire logic [2:0]                    cpuBusDataParity,
	input  wire logic [2:0]                    firstPciError,
	input  wire logic                          firstPciAddrParity,
	input  wire logic [2:0]                    firstPciRetryLimit,
	input  wire logic [2:0]                    secondPciError,
	input  wire logic                          secondPciAddrParity,
	input  wire logic [2:0]                    secondPciRetryLimit,
	input  wire logic [bisem_pkg::NUM_PIN-1:0] irqPinIn,
	output logic      [bisem_pkg::NUM_PIN-1:0] irqPinOut,
	output logic      [bisem_pkg::NUM_PIN-1:0] irqPinOe_b
);

	// whole state of the block in one word
	typedef struct packed {
		logic [bisem_pkg::NUM_NORM-1:0]           statN;  // normal status
		logic [bisem_pkg::NUM_ERR-1:0]            statE;  // error status
		logic [bisem_pkg::NUM_NORM-1:0]           enN;    // normal enables
		logic [bisem_pkg::NUM_ERR-1:0]            enE;    // error enables
		logic [bisem_pkg::NUM_PIN-1:0]            dir;    // 1 = output
		logic [bisem_pkg::NUM_SRC*3-1:0]          map;    // pin code per source
		logic [bisem_pkg::NUM_MBOX*32-1:0]        mbox;   // mailbox words
		logic [bisem_pkg::NUM_PIN-1:0]            syncA;  // first sync stage
		logic [bisem_pkg::NUM_PIN-1:0]            syncB;  // second sync stage
		logic [bisem_pkg::NUM_PIN-1:0]            syncC;  // third sync stage
		logic [bisem_pkg::NUM_PIN-1:0]            filt;   // agreed pin level
		logic [bisem_pkg::DATA_W-1:0]             rdData; // read answer
	} bisem_state_t;

	bisem_state_t                        s_r;     // registered state
	bisem_state_t                        s_nxt;   // next state
	logic [bisem_pkg::NUM_NORM-1:0]      setN;    // status sets, normal: hardware events plus doorbell and mailbox writes
	logic [bisem_pkg::NUM_NORM-1:0]      clrN;    // software clears, normal
	logic [bisem_pkg::NUM_ERR-1:0]       setE;    // hardware sets, error
	logic [bisem_pkg::NUM_ERR-1:0]       clrE;    // software clears, error
	logic [bisem_pkg::NUM_SRC-1:0]       act;     // status set and enabled; doorbells need no enable
	logic [bisem_pkg::NUM_PIN-1:0]       drv;     // pin pulled low
	logic                                mapHit;  // access hits a mapping word
	logic                                mboxHit; // access hits a mailbox
	logic [2:0]                          winIdx;  // word index inside a window
	logic [bisem_pkg::DATA_W-1:0]        rdMux;   // read value before the flop

	// window decode shared by reads and writes
	assign winIdx  = addr[4:2];
	assign mapHit  = (addr[7:5] == bisem_pkg::OFF_MAP[7:5]) && (addr[1:0] == 2'h0)
		&& (int'(winIdx) < bisem_pkg::NUM_MAPR);
	assign mboxHit = (addr[7:5] == bisem_pkg::OFF_MBOX[7:5]) && (addr[1:0] == 2'h0);

	// doorbells have no enable of their own, so they always count as enabled
	assign act = {s_r.statE & s_r.enE, s_r.statN & (s_r.enN | bisem_pkg::EN_N_DB)}; // see [R5] [R15]

	// per pin: or of every active source whose code names this pin
	for (genvar p = 0; p < bisem_pkg::NUM_PIN; p++) begin : g_pin
		logic hit; // some active source maps here
		always_comb begin
			hit = 1'b0;
			for (int s = 0; s < bisem_pkg::NUM_SRC; s++) begin
				// code 0 and 1 are the pci pins, 2..7 the general pins
				if (act[s] && (s_r.map[s*3 +: 3] == 3'(p))) begin // see [R16] [R27]
					hit = 1'b1;
				end
			end
		end
		assign drv[p] = s_r.dir[p] & hit; // see [R17] [R28]
	end

	// open drain: the pin only ever pulls low, enable is low while pulling
	assign irqPinOut  = '0;   // see [R25]
	assign irqPinOe_b = ~drv; // see [R5] [R28]
	assign rdData     = s_r.rdData;

	// error events, tagged by interface and, except address parity, by path
	assign setE[bisem_pkg::POS_PB_RTY +: 3]  = cpuBusRetryLimit;                 // see [R20]
	assign setE[bisem_pkg::POS_PB_ERR +: 3]  = cpuBusSlaveXferErr
		| cpuBusMasterXferErr;                                                   // see [R21]
	assign setE[bisem_pkg::POS_PB_APAR]      = cpuBusAddrParity;                 // see [R22]
	assign setE[bisem_pkg::POS_PB_DPAR +: 3] = cpuBusDataParity;                 // see [R19]
	assign setE[bisem_pkg::POS_P1_ERR +: 3]  = firstPciError;                    // see [R18]
	assign setE[bisem_pkg::POS_P1_APAR]      = firstPciAddrParity;               // see [R22]
	assign setE[bisem_pkg::POS_P1_RTY +: 3]  = firstPciRetryLimit;               // see [R20]
	assign setE[bisem_pkg::POS_P2_ERR +: 3]  = secondPciError;                   // see [R18]
	assign setE[bisem_pkg::POS_P2_APAR]      = secondPciAddrParity;              // see [R22]
	assign setE[bisem_pkg::POS_P2_RTY +: 3]  = secondPciRetryLimit;              // see [R20]

	// read multiplexer; summaries are live, unmapped words read zero
	always_comb begin
		rdMux = '0;
		if (addr == bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL) begin
			rdMux[bisem_pkg::NUM_NORM-1:0] = s_r.statN;
			rdMux[bisem_pkg::POS_SUM]      = |s_r.statE; // see [R6]
		end else if (addr == bisem_pkg::OFF_INTERRUPT_STATUS_ERROR) begin
			rdMux[bisem_pkg::NUM_ERR-1:0]  = s_r.statE;
			rdMux[bisem_pkg::POS_SUM]      = |s_r.statN; // see [R7]
		end else if (addr == bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL) begin
			// doorbell set bits are write only and read back zero
			rdMux[bisem_pkg::NUM_NORM-1:0] = s_r.enN & bisem_pkg::EN_N_RW;
		end else if (addr == bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR) begin
			rdMux[bisem_pkg::NUM_ERR-1:0]  = s_r.enE;
		end else if (addr == bisem_pkg::OFF_DIR) begin
			rdMux[bisem_pkg::NUM_PIN-1:0]  = s_r.dir;
		end else if (mapHit) begin
			for (int j = 0; j < bisem_pkg::MAP_PER; j++) begin
				if (int'(winIdx) * bisem_pkg::MAP_PER + j < bisem_pkg::NUM_SRC) begin
					rdMux[j*3 +: 3] = s_r.map[(int'(winIdx) * bisem_pkg::MAP_PER + j) * 3 +: 3];
				end
			end
		end else if (mboxHit) begin
			rdMux = s_r.mbox[int'(winIdx)*32 +: 32]; // see [R14]
		end
	end

	// next state: sync chain, register writes, sticky status
	always_comb begin
		s_nxt = s_r;
		setN  = '0;
		clrN  = '0;
		clrE  = '0;
		// pin sampling, a change counts once stages two and three agree
		s_nxt.syncA = irqPinIn;
		s_nxt.syncB = s_r.syncA;
		s_nxt.syncC = s_r.syncB;
		for (int p = 0; p < bisem_pkg::NUM_PIN; p++) begin
			if (s_r.syncB[p] == s_r.syncC[p]) begin
				s_nxt.filt[p] = s_r.syncC[p]; // see [R24]
			end
		end
		// hardware sources of the normal register
		setN[bisem_pkg::POS_IOP]              = inboundPending;          // see [R9]
		setN[bisem_pkg::POS_DMA +: bisem_pkg::NUM_DMA] = dmaIrq;         // see [R10]
		// an output pin sees its own drive, so only inputs raise status
		setN[bisem_pkg::POS_PIN +: bisem_pkg::NUM_PIN] = ~s_r.dir & ~s_r.filt; // see [R11]
		// register writes
		if (wrStb) begin
			if (addr == bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL) begin
				clrN = wrData[bisem_pkg::NUM_NORM-1:0]; // see [R2] [R26]
			end else if (addr == bisem_pkg::OFF_INTERRUPT_STATUS_ERROR) begin
				clrE = wrData[bisem_pkg::NUM_ERR-1:0]; // see [R2]
			end else if (addr == bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL) begin
				s_nxt.enN = wrData[bisem_pkg::NUM_NORM-1:0] & bisem_pkg::EN_N_RW; // see [R15]
				setN[bisem_pkg::POS_DB +: bisem_pkg::NUM_DB] =
					wrData[bisem_pkg::POS_DB +: bisem_pkg::NUM_DB]; // see [R12]
			end else if (addr == bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR) begin
				s_nxt.enE = wrData[bisem_pkg::NUM_ERR-1:0];
			end else if (addr == bisem_pkg::OFF_DIR) begin
				s_nxt.dir = wrData[bisem_pkg::NUM_PIN-1:0]; // see [R17]
			end else if (mapHit) begin
				for (int j = 0; j < bisem_pkg::MAP_PER; j++) begin
					if (int'(winIdx) * bisem_pkg::MAP_PER + j < bisem_pkg::NUM_SRC) begin
						s_nxt.map[(int'(winIdx) * bisem_pkg::MAP_PER + j) * 3 +: 3] =
							wrData[j*3 +: 3]; // see [R16]
					end
				end
			end else if (mboxHit) begin
				s_nxt.mbox[int'(winIdx)*32 +: 32] = wrData;  // see [R14]
				setN[bisem_pkg::POS_MBOX + int'(winIdx)] = 1'b1; // see [R13]
			end
		end
		// set beats clear so an event in the clearing cycle survives
		s_nxt.statN = (s_r.statN & ~clrN) | setN; // see [R1] [R2]
		s_nxt.statE = (s_r.statE & ~clrE) | setE; // see [R1] [R2]
		// host bit is a plain mirror of the outbound queue, not sticky
		s_nxt.statN[bisem_pkg::POS_HOST] = outboundPending; // see [R8]
		// read data stand only in the cycle after the strobe
		s_nxt.rdData = rdStb ? rdMux : '0;
	end

	// state register; sync stages idle high so no pin status after reset
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_r       <= '0;                  // see [R3] [R4]
			s_r.dir   <= bisem_pkg::DIR_RST;  // see [R25]
			s_r.syncA <= bisem_pkg::PIN_IDLE;
			s_r.syncB <= bisem_pkg::PIN_IDLE;
			s_r.syncC <= bisem_pkg::PIN_IDLE;
			s_r.filt  <= bisem_pkg::PIN_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_rst_status; // see [R3]
		@(posedge clk) disable iff (1'b0)
		!rst_b |=> (s_r.statN == '0) && (s_r.statE == '0);
	endproperty
	a_rst_status: assert property (p_rst_status) // see [R3]
		else $error("status not clear after reset");

	property p_rst_enable; // see [R4]
		@(posedge clk) disable iff (1'b0)
		!rst_b |=> (s_r.enN == '0) && (s_r.enE == '0) && (irqPinOe_b == '1);
	endproperty
	a_rst_enable: assert property (p_rst_enable) // see [R4]
		else $error("enables not clear after reset");

	property p_dma_set; // see [R1]
		dmaIrq[0] |=> s_r.statN[bisem_pkg::POS_DMA] [*2] or
			(s_r.statN[bisem_pkg::POS_DMA] ##1 $past(wrStb));
	endproperty
	a_dma_set: assert property (p_dma_set) // see [R1]
		else $error("dma event lost");

	property p_w0_keeps; // see [R2]
		(wrStb && addr == bisem_pkg::OFF_INTERRUPT_STATUS_ERROR && !wrData[0] && s_r.statE[0]) |=> s_r.statE[0];
	endproperty
	a_w0_keeps: assert property (p_w0_keeps) // see [R2]
		else $error("write zero cleared a bit");

	property p_w1_clears; // see [R2]
		(wrStb && addr == bisem_pkg::OFF_INTERRUPT_STATUS_ERROR && wrData[0] && !cpuBusRetryLimit[0])
			|=> !s_r.statE[0];
	endproperty
	a_w1_clears: assert property (p_w1_clears) // see [R2]
		else $error("write one did not clear");

	property p_sum_normal; // see [R6]
		(rdStb && addr == bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL)
			|=> rdData[bisem_pkg::POS_SUM] == (|$past(s_r.statE));
	endproperty
	a_sum_normal: assert property (p_sum_normal) // see [R6]
		else $error("error summary wrong");

	property p_sum_error; // see [R7]
		(rdStb && addr == bisem_pkg::OFF_INTERRUPT_STATUS_ERROR)
			|=> rdData[bisem_pkg::POS_SUM] == (|$past(s_r.statN));
	endproperty
	a_sum_error: assert property (p_sum_error) // see [R7]
		else $error("normal summary wrong");

	property p_host_mirror; // see [R8]
		outboundPending |=> s_r.statN[bisem_pkg::POS_HOST];
	endproperty
	a_host_mirror: assert property (p_host_mirror) // see [R8]
		else $error("host bit not mirrored");

	property p_doorbell; // see [R12]
		(wrStb && addr == bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL && wrData[bisem_pkg::POS_DB])
			|=> s_r.statN[bisem_pkg::POS_DB];
	endproperty
	a_doorbell: assert property (p_doorbell) // see [R12]
		else $error("doorbell not set");

	property p_mailbox; // see [R13]
		(wrStb && addr == bisem_pkg::OFF_MBOX)
			|=> s_r.statN[bisem_pkg::POS_MBOX] && (s_r.mbox[31:0] == $past(wrData));
	endproperty
	a_mailbox: assert property (p_mailbox) // see [R13]
		else $error("mailbox write not flagged");

	property p_pin_sample; // see [R24]
		(!irqPinIn[0] && !s_r.dir[0] && !wrStb) [*4] |-> ##2 s_r.statN[bisem_pkg::POS_PIN];
	endproperty
	a_pin_sample: assert property (p_pin_sample) // see [R24]
		else $error("pin input not flagged");

	property p_input_free; // see [R17]
		!s_r.dir[3] |-> irqPinOe_b[3];
	endproperty
	a_input_free: assert property (p_input_free) // see [R17]
		else $error("input pin driven");

	property p_map_drive; // see [R28]
		(s_r.dir[2] && s_r.statE[0] && s_r.enE[0] && s_r.map[bisem_pkg::NUM_NORM*3 +: 3] == 3'h2)
			|-> !irqPinOe_b[2];
	endproperty
	a_map_drive: assert property (p_map_drive) // see [R28]
		else $error("mapped pin not driven");

	property p_drive_cause; // see [R5]
		!irqPinOe_b[1] |-> s_r.dir[1] && (|act);
	endproperty
	a_drive_cause: assert property (p_drive_cause) // see [R5]
		else $error("pin driven without source");

	property p_iop_set; // see [R9]
		inboundPending |=> s_r.statN[bisem_pkg::POS_IOP];
	endproperty
	a_iop_set: assert property (p_iop_set) // see [R9]
		else $error("iop message bit not set");

	property p_retry_set; // see [R20]
		firstPciRetryLimit[2] |=> s_r.statE[bisem_pkg::POS_P1_RTY + 2];
	endproperty
	a_retry_set: assert property (p_retry_set) // see [R20]
		else $error("retry limit not flagged");

	// mailbox words only move on a write that hits the mailbox window
	property p_mbox_keep; // see [R14]
		!(wrStb && mboxHit) |=> $stable(s_r.mbox);
	endproperty
	a_mbox_keep: assert property (p_mbox_keep) // see [R14]
		else $error("mailbox changed without a write");

endmodule // bisem_intc

`default_nettype wire

// file: inc/bisem_pkg.sv
// constants, offsets and field layout of the bridge interrupt gathering block
`default_nettype none
package bisem_pkg;
	// register bus
	localparam int        ADDR_W    = 8;
	localparam int        DATA_W    = 32;
	localparam bit [7:0]  OFF_INTERRUPT_STATUS_NORMAL  = 8'h00; // interrupt_status_normal
	localparam bit [7:0]  OFF_INTERRUPT_STATUS_ERROR  = 8'h04; // interrupt_status_error
	localparam bit [7:0]  OFF_INTERRUPT_ENABLE_NORMAL  = 8'h08; // interrupt_enable_normal
	localparam bit [7:0]  OFF_INTERRUPT_ENABLE_ERROR  = 8'h0c; // interrupt_enable_error
	localparam bit [7:0]  OFF_DIR   = 8'h10; // pin direction
	localparam bit [7:0]  OFF_MAP   = 8'h20; // first of the mapping words
	localparam bit [7:0]  OFF_MBOX  = 8'h40; // first of the mailboxes
	// counts
	localparam int        NUM_PIN   = 8;
	localparam int        NUM_DMA   = 4;
	localparam int        NUM_DB    = 8;
	localparam int        NUM_MBOX  = 8;
	localparam int        NUM_NORM  = 30;
	localparam int        NUM_ERR   = 24;
	localparam int        NUM_SRC   = NUM_NORM + NUM_ERR;
	localparam int        MAP_W     = 3;
	localparam int        MAP_PER   = 8;
	localparam int        NUM_MAPR  = 7;
	// normal status / enable field positions
	localparam int        POS_MBOX  = 0;
	localparam int        POS_DB    = 8;
	localparam int        POS_PIN   = 16;
	localparam int        POS_DMA   = 24;
	localparam int        POS_IOP   = 28;
	localparam int        POS_HOST  = 29;
	localparam int        POS_SUM   = 31;
	// error field positions; groups of three are ordered cpu bus, first pci, second pci
	localparam int        POS_PB_RTY  = 0;
	localparam int        POS_PB_ERR  = 3;
	localparam int        POS_PB_APAR = 6;
	localparam int        POS_PB_DPAR = 7;
	localparam int        POS_P1_ERR  = 10;
	localparam int        POS_P1_APAR = 13;
	localparam int        POS_P1_RTY  = 14;
	localparam int        POS_P2_ERR  = 17;
	localparam int        POS_P2_APAR = 20;
	localparam int        POS_P2_RTY  = 21;
	// reset values and masks
	localparam bit [29:0] EN_N_RW   = 30'h3fff00ff;
	localparam bit [29:0] EN_N_DB   = 30'h0000ff00;
	localparam bit [7:0]  DIR_RST   = 8'h00;
	localparam bit [7:0]  PIN_IDLE  = 8'hff;
endpackage
`default_nettype wire

// file: verif/bisem_pin_agent.sv
// far-side agent on the eight open-drain interrupt pins
`timescale 1ns/1ns
`default_nettype none
module bisem_pin_agent (
	input  wire logic [bisem_pkg::NUM_PIN-1:0] pinOut,   // block output value, always low
	input  wire logic [bisem_pkg::NUM_PIN-1:0] pinOe_b,  // low while the block pulls
	input  wire logic [bisem_pkg::NUM_PIN-1:0] pullLow,  // far-side agents pulling the line
	output logic      [bisem_pkg::NUM_PIN-1:0] pinLevel  // resolved wire level
);
	// wired-and with a board pull-up: a released line returns to 1, never keeps the old value
	always_comb begin
		for (int i = 0; i < bisem_pkg::NUM_PIN; i++) begin
			pinLevel[i] = !((!pinOe_b[i] && !pinOut[i]) || pullLow[i]);
		end
	end
endmodule // bisem_pin_agent
`default_nettype wire

// file: verif/bisem_intc_tb.sv
// self-checking bench for the interrupt gathering block
`timescale 1ns/1ns
`default_nettype none
module bisem_intc_tb;
	logic        clk = 1'b0;              // 10 MHz bench clock
	logic        rst_b = 1'b0;            // synchronous reset, held at start
	logic [7:0]  addr = '0;               // register bus
	logic [31:0] wrData = '0;
	logic        wrStb = 1'b0;
	logic        rdStb = 1'b0;
	logic [31:0] rdData;
	logic        outboundPending = 1'b0;  // queue levels
	logic        inboundPending = 1'b0;
	logic [3:0]  dmaIrq = '0;
	logic [2:0]  cpuRty = '0, cpuSlvErr = '0, cpuMstErr = '0, cpuDPar = '0;
	logic        cpuAPar = 1'b0, p1APar = 1'b0, p2APar = 1'b0;
	logic [2:0]  p1Err = '0, p1Rty = '0, p2Err = '0, p2Rty = '0;
	logic [7:0]  pullLow = '0;            // far-side pull-downs
	logic [7:0]  irqPinOut, irqPinOe_b, pinLevel;
	int          errCount = 0;
	int          testsRun = 0;

	// clock: 100 ns period
	initial begin
		forever #50 clk = ~clk;
	end

	bisem_intc u_bisem_intc (.clk(clk), .rst_b(rst_b), .addr(addr), .wrData(wrData),
		.wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .outboundPending(outboundPending),
		.inboundPending(inboundPending), .dmaIrq(dmaIrq), .cpuBusRetryLimit(cpuRty),
		.cpuBusSlaveXferErr(cpuSlvErr), .cpuBusMasterXferErr(cpuMstErr),
		.cpuBusAddrParity(cpuAPar), .cpuBusDataParity(cpuDPar), .firstPciError(p1Err),
		.firstPciAddrParity(p1APar), .firstPciRetryLimit(p1Rty), .secondPciError(p2Err),
		.secondPciAddrParity(p2APar), .secondPciRetryLimit(p2Rty), .irqPinIn(pinLevel),
		.irqPinOut(irqPinOut), .irqPinOe_b(irqPinOe_b));

	bisem_pin_agent u_bisem_pin_agent (.pinOut(irqPinOut), .pinOe_b(irqPinOe_b),
		.pullLow(pullLow), .pinLevel(pinLevel));

	// single compare point; four-state equality so an unknown never matches
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errCount++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStb <= 1'b1;
		@(posedge clk);
		wrStb <= 1'b0;
	endtask

	// one-cycle read strobe; data stands only in the following cycle
	task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rdStb <= 1'b1;
		@(posedge clk);
		rdStb <= 1'b0;
		#1;
		chk(n, rdData, e);
	endtask

	// enable lines and the resolved wires must agree once outputs settle
	task automatic pinChk(input string n, input logic [7:0] e);
		#1;
		chk(n, {24'h0, irqPinOe_b}, {24'h0, e});
		chk(n, {24'h0, pinLevel}, {24'h0, e});
	endtask

	// one-cycle pulse on the exception inputs (slave or master transfer error as selected), laid out as the error status word
	task automatic pulseErr(input logic [23:0] v, input logic viaMaster);
		@(posedge clk);
		cpuRty <= v[2:0];
		if (viaMaster) begin
			cpuMstErr <= v[5:3];
		end else begin
			cpuSlvErr <= v[5:3];
		end
		cpuAPar <= v[6];
		cpuDPar <= v[9:7];
		p1Err <= v[12:10];
		p1APar <= v[13];
		p1Rty <= v[16:14];
		p2Err <= v[19:17];
		p2APar <= v[20];
		p2Rty <= v[23:21];
		@(posedge clk);
		{cpuRty, cpuSlvErr, cpuMstErr, cpuAPar, cpuDPar, p1Err, p1APar, p1Rty} <= '0;
		{p2Err, p2APar, p2Rty} <= '0;
	endtask

	task automatic tdone(input string n);
		$display("test %s done", n);
	endtask

	// single place where the run ends
	task automatic endOfTest();
		$display("comparisons %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		errCount++;
		endOfTest();
	end

	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rdChk("status normal", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, '0);
		rdChk("status error", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, '0);
		rdChk("enable normal", bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, '0);
		rdChk("enable error", bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, '0);
		rdChk("direction", bisem_pkg::OFF_DIR, '0);
		pinChk("pins idle", 8'hff);
		wr(8'h60, '1);
		rdChk("unmapped", 8'h60, '0);
		wr(8'h3c, '1);
		rdChk("map beyond last", 8'h3c, '0);
		tdone("reset");
		// every mailbox holds its word; each write flags its status bit
		for (int i = 0; i < 8; i++) wr(bisem_pkg::OFF_MBOX + 8'(4 * i), 32'h5a5a0f00 + 32'(i));
		for (int i = 0; i < 8; i++) begin
			rdChk("mailbox", bisem_pkg::OFF_MBOX + 8'(4 * i), 32'h5a5a0f00 + 32'(i));
		end
		rdChk("mailbox status", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h000000ff);
		rdChk("normal summary", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h80000000);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0);
		rdChk("write zero keeps", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h000000ff);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0000000f);
		rdChk("write one clears", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h000000f0);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h000000f0);
		tdone("mailbox");
		// doorbells: set through the enable word, cleared through the status word
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h0000a500);
		rdChk("doorbell set", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0000a500);
		rdChk("doorbell reads 0", bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h0);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h00000500);
		rdChk("doorbell clear", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0000a000);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h3fffffff);
		rdChk("enable rw", bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, {2'b00, bisem_pkg::EN_N_RW});
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h0);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0000ff00);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, 32'h00a5a5a5);
		rdChk("error enable rw", bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, 32'h00a5a5a5);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, 32'h0);
		tdone("doorbell");
		// exception events, slave then master side of the cpu bus error
		pulseErr(24'h555555, 1'b0);
		rdChk("error status", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h00555555);
		rdChk("error summary", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h80000000);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h0);
		rdChk("error write zero", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h00555555);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h80000055);
		rdChk("error clear", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h00555500);
		pulseErr(24'haaaaaa, 1'b1);
		rdChk("error master", bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h00ffffaa);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, '1);
		tdone("errors");
		// dma, inbound and outbound queue sources
		@(posedge clk);
		inboundPending <= 1'b1;
		dmaIrq <= 4'h9;
		outboundPending <= 1'b1;
		@(posedge clk);
		inboundPending <= 1'b0;
		dmaIrq <= 4'h0;
		rdChk("queue dma", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h39000000);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h3f000000);
		rdChk("host stays", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h20000000);
		@(posedge clk);
		outboundPending <= 1'b0;
		rdChk("host follows", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0);
		tdone("queues");
		// input pins: a one-cycle glitch is filtered, a held level is flagged
		@(posedge clk);
		pullLow <= 8'h20;
		@(posedge clk);
		pullLow <= 8'h00;
		repeat (8) @(posedge clk);
		rdChk("glitch", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			pullLow <= 8'(1 << i);
			repeat (8) @(posedge clk);
			pullLow <= 8'h00;
			rdChk("pin input", bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'(1) << (16 + i));
			// the last low sample still sets status a few edges on; clear after it
			repeat (4) @(posedge clk);
			wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h00ff0000);
		end
		tdone("pin input");
		// output mapping: mailbox 0 steered through every code
		wr(bisem_pkg::OFF_DIR, 32'h000000ff);
		wr(bisem_pkg::OFF_MBOX, 32'h1);
		pinChk("not enabled", 8'hff);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h1);
		for (int c = 0; c < 8; c++) begin
			wr(bisem_pkg::OFF_MAP, 32'(c));
			pinChk("mapped pin", ~(8'h01 << c));
		end
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_NORMAL, 32'h1);
		pinChk("cleared", 8'hff);
		// error source 30 (fourth map word, bits 20:18) steered to pin 2
		wr(bisem_pkg::OFF_MAP + 8'h0c, 32'h00090000);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, 32'h1);
		pulseErr(24'h000001, 1'b0);
		pinChk("error mapped", 8'hfb);
		wr(bisem_pkg::OFF_INTERRUPT_STATUS_ERROR, 32'h1);
		pinChk("error cleared", 8'hff);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_ERROR, 32'h0);
		// host mask: source 29 sits in the fourth map word, bits 17:15
		wr(bisem_pkg::OFF_MAP + 8'h0c, 32'h00010000);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h20000000);
		@(posedge clk);
		outboundPending <= 1'b1;
		repeat (2) @(posedge clk);
		pinChk("host unmasked", 8'hfb);
		wr(bisem_pkg::OFF_INTERRUPT_ENABLE_NORMAL, 32'h0);
		pinChk("host masked", 8'hff);
		tdone("output map");
		endOfTest();
	end
endmodule // bisem_intc_tb
`default_nettype wire
